// ==== src/spmh_pkg.sv ====
// Package for the phase-mismatch handler: states, cause codes, widths and offsets.
// Assumes a single 50 MHz clock domain and a synchronous active-high reset.
package spmh_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned COUNT_W = 24;
  localparam logic [31:0] PREFETCH_OFFSET = 32'h0000_0008;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] RESET_COUNT = 24'h00_0000;
  localparam int unsigned BUF_DEPTH = 16;

  typedef enum logic [5:0]
  {
    SPMH_IDLE = 6'h01,
    SPMH_FETCH = 6'h02,
    SPMH_MOVE = 6'h04,
    SPMH_DRAIN = 6'h08,
    SPMH_HALT = 6'h10,
    SPMH_TEST = 6'h20
  } spmh_state_e;

  typedef enum logic [1:0]
  {
    SPMH_CAUSE_NONE = 2'h0,
    SPMH_CAUSE_DATA_IN = 2'h1,
    SPMH_CAUSE_DATA_OUT = 2'h2
  } spmh_cause_e;

  typedef enum logic [2:0]
  {
    SPMH_OP_MOVE_IN = 3'h0,
    SPMH_OP_MOVE_OUT = 3'h1,
    SPMH_OP_CALL_NONDATA = 3'h2,
    SPMH_OP_COMPLETE = 3'h3,
    SPMH_OP_STOP = 3'h4
  } spmh_op_e;

endpackage

// ==== src/spmh_level_counter.sv ====
// Byte level counter of the chip's data buffer between the link and the DMA core.
// Ignores a push when full and a pop when empty, so the level stays between zero and DEPTH.
module spmh_level_counter #(
  parameter int unsigned DEPTH = spmh_pkg::BUF_DEPTH
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic push_in,
  input wire logic pop_in,
  output logic [$clog2(DEPTH+1)-1:0] level_out,
  output logic empty_out,
  output logic full_out
);

  localparam int unsigned LW = $clog2(DEPTH + 1);

  initial
  begin
    if (DEPTH < 1)
    begin
      $error("DEPTH must be at least one");
    end
  end

  logic [LW-1:0] level_reg;
  logic [LW-1:0] level_next;

  always_comb
  begin
    level_next = level_reg;
    if (push_in && !pop_in && !full_out)
    begin
      level_next = level_reg + LW'(1);
    end
    else if (pop_in && !push_in && !empty_out)
    begin
      level_next = level_reg - LW'(1);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      level_reg <= '0;
    end
    else
    begin
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
  assign empty_out = (level_reg == '0);
  assign full_out = (level_reg == LW'(DEPTH));

endmodule // spmh_level_counter

// ==== src/spmh_handler.sv ====
// Phase-mismatch handling of the instruction sequencer for block moves on the bus.
// Assumes instructions arrive on a fetch handshake and bytes move on one-cycle strobes.
// Functional notes
// - An unexpected phase change while a move has bytes left halts execution and interrupts the host.
// - On data-in the held bytes are flushed to memory first, and only then does the block halt and interrupt.
// - On data-out the block halts after the change and interrupts, leaving fetched bytes in its buffer.
// - The instruction pointer reads as the executing instruction's address plus eight.
// - Back-to-back moves without a phase test start at once, and a change then is a normal mismatch.
// - A move finished just before the phase change leaves nothing buffered, so a non-data call goes on without interrupt.
// - A non-halting completion signal tells the host an I/O is done without stopping execution.
module spmh_handler #(
  parameter int unsigned DEPTH = spmh_pkg::BUF_DEPTH
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [spmh_pkg::ADDR_W-1:0] start_addr_in,
  input wire logic resume_in,
  output logic fetch_req_out,
  output logic [spmh_pkg::ADDR_W-1:0] fetch_addr_out,
  input wire logic fetch_valid_in,
  input wire logic [2:0] fetch_op_in,
  input wire logic [spmh_pkg::COUNT_W-1:0] fetch_count_in,
  input wire logic [spmh_pkg::ADDR_W-1:0] fetch_mem_addr_in,
  input wire logic phase_is_data_in,
  input wire logic phase_changed_in,
  input wire logic link_byte_in,
  input wire logic dma_byte_in,
  output logic link_req_out,
  output logic dma_req_out,
  output logic [spmh_pkg::ADDR_W-1:0] instr_ptr_out,
  output logic [spmh_pkg::COUNT_W-1:0] byte_count_out,
  output logic [spmh_pkg::ADDR_W-1:0] mem_addr_out,
  output logic [$clog2(DEPTH+1)-1:0] buffered_out,
  output logic [1:0] halt_cause_out,
  output logic halted_out,
  output logic irq_out,
  output logic done_pulse_out
);

  localparam int unsigned LW = $clog2(DEPTH + 1);

  initial
  begin
    if (DEPTH < 2)
    begin
      $error("DEPTH must be at least two");
    end
  end

  spmh_pkg::spmh_state_e state_reg;
  spmh_pkg::spmh_state_e state_next;
  logic [spmh_pkg::ADDR_W-1:0] cur_reg;
  logic [spmh_pkg::ADDR_W-1:0] cur_next;
  logic [spmh_pkg::COUNT_W-1:0] count_reg;
  logic [spmh_pkg::COUNT_W-1:0] count_next;
  logic [spmh_pkg::ADDR_W-1:0] addr_reg;
  logic [spmh_pkg::ADDR_W-1:0] addr_next;
  logic dir_in_reg;
  logic dir_in_next;
  logic [1:0] cause_reg;
  logic [1:0] cause_next;
  logic irq_reg;
  logic irq_next;
  logic done_reg;
  logic done_next;
  logic push;
  logic pop;
  logic buf_empty;
  logic buf_full;
  logic [LW-1:0] level;
  logic bytes_left;

  // Data-in fills from the link and drains to memory; data-out fills from memory and drains to the link.
  assign push = dir_in_reg ? link_byte_in : dma_byte_in;
  assign pop = dir_in_reg ? dma_byte_in : link_byte_in;
  // A data-out move still owes the bus every byte it holds, even once memory has delivered all of them.
  assign bytes_left = (count_reg != '0) || (!dir_in_reg && !buf_empty);

  spmh_level_counter #(
    .DEPTH(DEPTH)
  ) u_level (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .push_in(push),
    .pop_in(pop),
    .level_out(level),
    .empty_out(buf_empty),
    .full_out(buf_full)
  );

  always_comb
  begin
    state_next = state_reg;
    cur_next = cur_reg;
    count_next = count_reg;
    addr_next = addr_reg;
    dir_in_next = dir_in_reg;
    cause_next = cause_reg;
    irq_next = irq_reg;
    done_next = 1'b0;
    // Memory-side bytes are counted in every state, so a late byte after a halt stays accounted for.
    // On data-out the byte counter follows memory, so counter plus buffered bytes is what the bus still owes.
    if (dma_byte_in && (dir_in_reg ? !buf_empty : !buf_full))
    begin
      addr_next = addr_reg + spmh_pkg::ADDR_W'(1);
      if (!dir_in_reg && count_reg != '0)
      begin
        count_next = count_reg - spmh_pkg::COUNT_W'(1);
      end
    end
    unique case (state_reg)
      spmh_pkg::SPMH_IDLE:
      begin
        if (start_in)
        begin
          cur_next = start_addr_in;
          cause_next = spmh_pkg::SPMH_CAUSE_NONE;
          state_next = spmh_pkg::SPMH_FETCH;
        end
      end
      spmh_pkg::SPMH_FETCH:
      begin
        if (fetch_valid_in)
        begin
          unique case (fetch_op_in)
            spmh_pkg::SPMH_OP_MOVE_IN, spmh_pkg::SPMH_OP_MOVE_OUT:
            begin
              count_next = fetch_count_in;
              addr_next = fetch_mem_addr_in;
              dir_in_next = (fetch_op_in == spmh_pkg::SPMH_OP_MOVE_IN);
              state_next = spmh_pkg::SPMH_MOVE;
            end
            spmh_pkg::SPMH_OP_CALL_NONDATA:
            begin
              state_next = spmh_pkg::SPMH_TEST;
            end
            spmh_pkg::SPMH_OP_COMPLETE:
            begin
              done_next = 1'b1;
              cur_next = cur_reg + spmh_pkg::PREFETCH_OFFSET;
            end
            default:
            begin
              state_next = spmh_pkg::SPMH_IDLE;
            end
          endcase
        end
      end
      spmh_pkg::SPMH_MOVE:
      begin
        if (dir_in_reg && link_byte_in && count_reg != '0)
        begin
          count_next = count_reg - spmh_pkg::COUNT_W'(1);
        end
        if (phase_changed_in && bytes_left)
        begin
          if (dir_in_reg)
          begin
            cause_next = spmh_pkg::SPMH_CAUSE_DATA_IN;
            state_next = spmh_pkg::SPMH_DRAIN;
          end
          else
          begin
            cause_next = spmh_pkg::SPMH_CAUSE_DATA_OUT;
            irq_next = 1'b1;
            state_next = spmh_pkg::SPMH_HALT;
          end
        end
        else if (count_reg == '0 && buf_empty)
        begin
          // A finished move waits until its buffer is empty so nothing stays buffered.
          cur_next = cur_reg + spmh_pkg::PREFETCH_OFFSET;
          state_next = spmh_pkg::SPMH_FETCH;
        end
      end
      spmh_pkg::SPMH_DRAIN:
      begin
        if (buf_empty)
        begin
          irq_next = 1'b1;
          state_next = spmh_pkg::SPMH_HALT;
        end
      end
      spmh_pkg::SPMH_HALT:
      begin
        if (resume_in)
        begin
          irq_next = 1'b0;
          cause_next = spmh_pkg::SPMH_CAUSE_NONE;
          state_next = spmh_pkg::SPMH_IDLE;
        end
      end
      spmh_pkg::SPMH_TEST:
      begin
        // A non-data call goes on without any host interrupt.
        cur_next = cur_reg + spmh_pkg::PREFETCH_OFFSET;
        state_next = spmh_pkg::SPMH_FETCH;
      end
      default:
      begin
        state_next = spmh_pkg::SPMH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= spmh_pkg::SPMH_IDLE;
      cur_reg <= spmh_pkg::RESET_ADDR;
      count_reg <= spmh_pkg::RESET_COUNT;
      addr_reg <= spmh_pkg::RESET_ADDR;
      dir_in_reg <= 1'b0;
      cause_reg <= spmh_pkg::SPMH_CAUSE_NONE;
      irq_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      count_reg <= count_next;
      addr_reg <= addr_next;
      dir_in_reg <= dir_in_next;
      cause_reg <= cause_next;
      irq_reg <= irq_next;
      done_reg <= done_next;
    end
  end

  assign fetch_req_out = (state_reg == spmh_pkg::SPMH_FETCH);
  assign fetch_addr_out = cur_reg;
  assign instr_ptr_out = cur_reg + spmh_pkg::PREFETCH_OFFSET;
  assign byte_count_out = count_reg;
  assign mem_addr_out = addr_reg;
  assign buffered_out = level;
  assign halt_cause_out = cause_reg;
  assign halted_out = (state_reg == spmh_pkg::SPMH_HALT);
  assign irq_out = irq_reg;
  assign done_pulse_out = done_reg;
  assign link_req_out = (state_reg == spmh_pkg::SPMH_MOVE) && !phase_changed_in
                        && (dir_in_reg ? (count_reg != '0 && !buf_full) : !buf_empty);
  // Data-out fetches stop at the move's own count so no byte of the next move is fetched early.
  assign dma_req_out = dir_in_reg
                       ? (((state_reg == spmh_pkg::SPMH_MOVE) || (state_reg == spmh_pkg::SPMH_DRAIN)) && !buf_empty)
                       : ((state_reg == spmh_pkg::SPMH_MOVE) && !buf_full && count_reg != '0);

endmodule // spmh_handler

// ==== dv/spmh_handler_props.sv ====
// Concurrent checks on the phase-mismatch handler's ports.
// Bound to every handler instance; one clock, synchronous reset.
module spmh_handler_props #(
  parameter int unsigned DEPTH = spmh_pkg::BUF_DEPTH
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic resume_in,
  input wire logic [$clog2(DEPTH+1)-1:0] buffered_out,
  input wire logic [1:0] halt_cause_out,
  input wire logic halted_out,
  input wire logic irq_out,
  input wire logic done_pulse_out,
  input wire logic fetch_req_out,
  input wire logic link_req_out,
  input wire logic dma_req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_hold;
    halted_out && !resume_in;
  endsequence
  sequence s_resume;
    halted_out && resume_in;
  endsequence
  a_reset_clears: assert property (disable iff (1'b0) rst_in |=> !irq_out && !halted_out && halt_cause_out == 2'h0)
    else $error("outputs not cleared by reset");
  a_irq_halted: assert property (irq_out |-> halted_out) else $error("interrupt without halt");
  a_halt_stands: assert property (s_hold |=> halted_out && irq_out && $stable(halt_cause_out))
    else $error("halt state lost before resume");
  a_resume_clears: assert property (s_resume |=> !irq_out && !halted_out) else $error("resume ignored");
  a_drain_empty: assert property ($rose(irq_out) && halt_cause_out == 2'h1 |-> buffered_out == '0)
    else $error("data-in halt with bytes held");
  a_cause_latched: assert property ($rose(halted_out) |-> halt_cause_out inside {2'h1, 2'h2})
    else $error("halt without cause");
  a_done_single: assert property (done_pulse_out |=> !done_pulse_out) else $error("completion pulse too long");
  a_done_runs: assert property (done_pulse_out |-> !halted_out && !irq_out)
    else $error("completion signal halted");
  a_halt_stops: assert property (halted_out |-> !fetch_req_out && !link_req_out && !dma_req_out)
    else $error("execution goes on while halted");
endmodule // spmh_handler_props
bind spmh_handler spmh_handler_props #(.DEPTH(DEPTH)) u_props (.clk_in, .rst_in, .resume_in, .buffered_out,
  .halt_cause_out, .halted_out, .irq_out, .done_pulse_out, .fetch_req_out, .link_req_out, .dma_req_out);

// ==== dv/spmh_target_model.sv ====
// Bus target: answers byte requests, optionally slowly, and changes phase after a byte count.
// A count of zero means no phase change.
module spmh_target_model
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic link_req_in,
  input wire logic slow_in,
  input wire logic arm_in,
  input wire logic [7:0] change_at_in,
  output logic link_byte_out,
  output logic phase_changed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sent_reg;
  logic tick_reg;
  always_ff @(posedge clk_in)
  begin
    tick_reg <= !rst_in && !tick_reg;
    link_byte_out <= !rst_in && link_req_in && !link_byte_out && (!slow_in || tick_reg);
    sent_reg <= (rst_in || !arm_in) ? 8'h00 : sent_reg + 8'(link_byte_out);
    phase_changed_out <= arm_in && change_at_in != 8'h00 && sent_reg == change_at_in;
  end
endmodule // spmh_target_model

// ==== dv/spmh_handler_tb.sv ====
// Self-checking bench for the phase-mismatch handler.
// The bench feeds instructions and memory bytes; the target model drives the bus side.
module spmh_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_in = 1'b0, resume_in = 1'b0, fetch_valid_in = 1'b0, dma_byte_in = 1'b0, slow = 1'b0, arm = 1'b0;
  logic [31:0] start_addr_in = 32'h0, fetch_mem_addr_in = 32'h0, base = 32'h0, mem0 = 32'h0;
  logic [2:0] fetch_op_in = 3'h0;
  logic [23:0] fetch_count_in = 24'h0;
  logic [7:0] change_at = 8'h00;
  logic link_byte_in, phase_changed_in, fetch_req_out, link_req_out, dma_req_out, halted_out, irq_out, done_pulse_out;
  logic [31:0] fetch_addr_out, instr_ptr_out, mem_addr_out;
  logic [23:0] byte_count_out;
  logic [4:0] buffered_out;
  logic [1:0] halt_cause_out;
  logic [2:0] prog_op [3];
  int n_fail = 0, compares = 0, pc = 0, done_seen = 0, irq_seen = 0, n = 0, moved = 0;
  always #10 clk_in = !clk_in;
  spmh_handler u_dut (.clk_in, .rst_in, .start_in, .start_addr_in, .resume_in, .fetch_req_out, .fetch_addr_out,
    .fetch_valid_in, .fetch_op_in, .fetch_count_in, .fetch_mem_addr_in, .phase_is_data_in(1'b0), .phase_changed_in,
    .link_byte_in, .dma_byte_in, .link_req_out, .dma_req_out, .instr_ptr_out, .byte_count_out, .mem_addr_out,
    .buffered_out, .halt_cause_out, .halted_out, .irq_out, .done_pulse_out);
  spmh_target_model u_tgt (.clk_in, .rst_in, .link_req_in(link_req_out), .slow_in(slow), .arm_in(arm),
    .change_at_in(change_at), .link_byte_out(link_byte_in), .phase_changed_out(phase_changed_in));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Memory side stalls at random; each fetch request is answered with the next program word.
  always @(posedge clk_in)
  begin
    dma_byte_in <= dma_req_out && !dma_byte_in && ($urandom % 3 != 0);
    fetch_valid_in <= fetch_req_out && !fetch_valid_in;
    // Bus bytes of the move in progress; a new fetch starts a new move.
    if (link_byte_in === 1'b1)
      moved = moved + 1;
    if (fetch_req_out && !fetch_valid_in)
    begin
      moved = 0;
      check("fetch_addr", fetch_addr_out, base + 32'(8 * pc));
      fetch_op_in <= prog_op[pc];
      pc = pc + 1;
    end
    if (done_pulse_out === 1'b1)
      done_seen = done_seen + 1;
    if (irq_out === 1'b1)
      irq_seen = 1;
  end
  task automatic run(input string tname, input logic [2:0] op0, input logic [2:0] op1, input int rel, input int off,
    input logic [1:0] cause, input int idx, input int dones);
    int i;
    @(posedge clk_in);
    n = 4 + $urandom % 9;
    base = $urandom & 32'hFFFF_FFF0;
    prog_op[0] = op0;
    prog_op[1] = op1;
    prog_op[2] = 3'h4;
    pc = 0;
    done_seen = 0;
    irq_seen = 0;
    slow <= 1'($urandom);
    fetch_count_in <= 24'(n);
    mem0 = $urandom;
    fetch_mem_addr_in <= mem0;
    start_addr_in <= base;
    change_at <= 8'(rel * n + off);
    arm <= 1'b1;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    for (i = 0; i < 2000 && halted_out !== 1'b1 && pc < 3; i++)
      @(posedge clk_in);
    if (i == 2000)
    begin
      n_fail = n_fail + 1;
      complete_run();
    end
    repeat (6) @(posedge clk_in);
    #1;
    check("halt_cause", halt_cause_out, cause);
    check("irq", irq_seen, cause != 2'h0);
    check("done", done_seen, dones);
    if (cause != 2'h0)
    begin
      check("instr_ptr", instr_ptr_out, base + 32'(8 * idx + 8));
      check("resume_entry", instr_ptr_out - 32'h0000_0008, base + 32'(8 * idx));
      check("resume_count", byte_count_out + buffered_out, 32'(n - moved));
      check("resume_addr", mem_addr_out - buffered_out, mem0 + 32'(moved));
    end
    resume_in <= cause != 2'h0;
    @(posedge clk_in);
    resume_in <= 1'b0;
    arm <= 1'b0;
    @(posedge clk_in);
    #1;
    check("halted", halted_out, 0);
    $display("test %s done", tname);
  endtask
  initial
  begin
    void'($urandom(79));
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2)
    begin
      run("in_mid", 3'h0, 3'h0, 0, 3, 2'h1, 0, 0);
      run("out_mid", 3'h1, 3'h1, 0, 2, 2'h2, 0, 0);
      run("in_next", 3'h0, 3'h0, 1, 1, 2'h1, 1, 0);
      run("out_next", 3'h1, 3'h1, 1, 1, 2'h2, 1, 0);
      run("edge_call", 3'h0, 3'h2, 1, 0, 2'h0, 0, 0);
      run("complete", 3'h3, 3'h0, 0, 0, 2'h0, 0, 1);
    end
    complete_run();
  end
endmodule // spmh_handler_tb
